// *** core/hostctl_pkg.sv ***
// Constants shared by the host-port control block
package hostctl_pkg;
	localparam int NUM_CHANNELS = 8;
	localparam int NUM_PORTS = 4;
	localparam int CHAN_IRQ_W = 16;
	localparam int PORT_IRQ_W = 8;
	localparam int GLOBAL_IRQ_W = 12;
	localparam int GIS_PORT_LSB = 8;
	localparam logic [CHAN_IRQ_W-1:0] CHAN_MASK_RESET = 16'hffff;
	localparam logic [PORT_IRQ_W-1:0] PORT_MASK_RESET = 8'hff;
	localparam logic [NUM_CHANNELS-1:0] POWER_RESET = 8'h00;
	localparam int ACK_DELAY_NS = 10;
	localparam int CLK_PERIOD_NS = 5;
	localparam int ACK_DELAY_CYC = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_CNT_W = 3;
	localparam int ALE_IDLE_CYC = 4;
	localparam int ALE_CNT_W = 3;

	typedef enum logic [1:0] {
		IRQ_PP_LOW = 2'b00,
		IRQ_PP_HIGH = 2'b01,
		IRQ_OPEN_DRAIN = 2'b10,
		IRQ_OPEN_DRAIN2 = 2'b11
	} irq_type_e;

	typedef enum logic [1:0] {
		BUS_DEMUX_I = 2'b00,
		BUS_DEMUX_M = 2'b01,
		BUS_MUX_I = 2'b10
	} bus_style_e;

	typedef enum logic [1:0] {
		ACK_IDLE = 2'b00,
		ACK_WAIT = 2'b01,
		ACK_HOLD = 2'b10
	} ack_state_e;
endpackage : hostctl_pkg

// *** core/irq_status_bank.sv ***
// Sticky interrupt status bits with software clear, set winning over clear
`timescale 1ns/1ps
module irq_status_bank
	import hostctl_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hard_clear,
	// Events and clears
	input wire logic [W-1:0] ev_set,
	input wire logic [W-1:0] sw_clear,
	input wire logic [W-1:0] mask,
	// Status
	output logic [W-1:0] status,
	output logic pending
);
	logic [W-1:0] status_reg;
	logic [W-1:0] status_next;

	// Each bit: unmasked event sets, clear drops, set wins
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				if (hard_clear) begin
					status_next[i] = 1'b0;
				end else if (ev_set[i] && !mask[i]) begin
					status_next[i] = 1'b1;
				end else if (sw_clear[i]) begin
					status_next[i] = 1'b0;
				end else begin
					status_next[i] = status_reg[i];
				end
			end
		end
	endgenerate

	// Status register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status = status_reg;
	assign pending = |status_reg;

	// A set and a clear together leave the bit set
	set_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		(!hard_clear && (ev_set[0] && !mask[0]) && sw_clear[0]) |=> status_reg[0])
		else $error("status bit lost on simultaneous set and clear");
endmodule : irq_status_bank

// *** core/bus_ack_unit.sv ***
// Transfer acknowledge sequencing and bus style detection
`timescale 1ns/1ps
module bus_ack_unit
	import hostctl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hard_clear,
	// Bus cycle qualifiers
	input wire logic cycle_req,
	input wire logic ale_in,
	// Results
	output logic ack_act,
	output bus_style_e style
);
	ack_state_e state_reg;
	ack_state_e state_next;
	logic [ACK_CNT_W-1:0] cnt_reg;
	logic [ACK_CNT_W-1:0] cnt_next;
	logic ale_prev_reg;
	logic ale_prev_next;
	logic [ALE_CNT_W-1:0] idle_reg;
	logic [ALE_CNT_W-1:0] idle_next;
	logic toggled_reg;
	logic toggled_next;
	logic ale_seen_reg;
	logic ale_seen_next;

	// Acknowledge state machine: wait, then hold until the cycle ends
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (hard_clear) begin
			state_next = ACK_IDLE;
			cnt_next = '0;
		end else begin
			unique case (state_reg)
				ACK_IDLE: begin
					cnt_next = '0;
					if (cycle_req) begin
						state_next = ACK_WAIT;
					end
				end
				ACK_WAIT: begin
					cnt_next = cnt_reg + 1'b1;
					if (!cycle_req) begin
						state_next = ACK_IDLE;
					end else if (cnt_reg == ACK_CNT_W'(ACK_DELAY_CYC - 1)) begin
						state_next = ACK_HOLD; // R12
					end
				end
				ACK_HOLD: begin
					if (!cycle_req) begin
						state_next = ACK_IDLE; // R13
					end
				end
				default: begin
					state_next = ACK_IDLE;
				end
			endcase
		end
	end

	// Style detection: a recent ALE edge means multiplexed operation
	always_comb begin
		ale_prev_next = ale_in;
		ale_seen_next = 1'b1; // First edge after reset only learns the pin level
		idle_next = idle_reg;
		toggled_next = toggled_reg;
		if (ale_seen_reg && ale_in != ale_prev_reg) begin
			idle_next = '0;
			toggled_next = 1'b1;
		end else if (idle_reg == ALE_CNT_W'(ALE_IDLE_CYC)) begin
			toggled_next = 1'b0;
		end else begin
			idle_next = idle_reg + 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ACK_IDLE;
			cnt_reg <= '0;
			ale_prev_reg <= 1'b0;
			idle_reg <= '0;
			toggled_reg <= 1'b0;
			ale_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ale_prev_reg <= ale_prev_next;
			idle_reg <= idle_next;
			toggled_reg <= toggled_next;
			ale_seen_reg <= ale_seen_next;
		end
	end

	assign ack_act = (state_reg == ACK_HOLD);
	assign style = toggled_reg ? BUS_MUX_I : (ale_prev_reg ? BUS_DEMUX_M : BUS_DEMUX_I); // R20

	// Acknowledge comes after the wait when the cycle stays up
	ack_time_a: assert property (@(posedge clk) disable iff (!rst_n || hard_clear) // R12
		(state_reg == ACK_IDLE && cycle_req) ##1 cycle_req [*2] |=> ack_act)
		else $error("acknowledge late");
	// Acknowledge drops one cycle after the cycle ends
	ack_release_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(ack_act && !cycle_req) |=> !ack_act)
		else $error("acknowledge held after release");
	// Acknowledge stays while the cycle stays
	ack_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(ack_act && cycle_req && !hard_clear) |=> ack_act)
		else $error("acknowledge dropped early");
endmodule : bus_ack_unit

// *** core/host_ctl.sv ***
// Host port control: reset, bus width, byte lanes, acknowledge, interrupt pin
// Contract
// R1 - Hard clear high puts the device in reset while held.
// R2 - Powered during hard clear; all channels powered down after release.
// R3 - Software sets channel power-up bits; channels never wake themselves.
// R4 - Output-only pins float during hard clear.
// R5 - Data lines float in hard clear when read strobe and irq ack high.
// R6 - Oscillator stopped in hard clear; its output floats while osc_in high.
// R7 - Sixteen-bit first style: byte select marks upper lane transfer.
// R8 - Sixteen-bit second style: byte select marks lower lane transfer.
// R9 - Eight-bit mode ignores byte select; host ties it high.
// R10 - Width input low selects 8-bit, high selects 16-bit with words.
// R11 - In 16-bit mode address bit zero plus byte select pick lanes.
// R12 - Acknowledge asserts when ready to complete the transfer.
// R13 - Acknowledge holds until strobe, select or irq ack go inactive.
// R14 - One interrupt pin merges all channel and enabled port sources.
// R15 - Every source maskable by channel and port mask registers.
// R16 - Pending shown in global, channel and port status registers.
// R17 - Interrupt pin: push-pull low, push-pull high or open drain.
// R18 - In chain mode the request is driven only while chain enable high.
// R19 - Request drops on chain enable low or all status bits clear.
// R20 - ALE low, high or toggling selects bus style.
`timescale 1ns/1ps
module host_ctl
	import hostctl_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic HARD_CLEAR_IN,
	// Bus pins
	input wire logic BUS_WIDE,
	input wire logic ALE_IN,
	input wire logic CS_N,
	input wire logic READ_N,
	input wire logic WRITE_N,
	input wire logic DATA_STROBE_N,
	input wire logic IRQ_ACK_IN,
	input wire logic ADDR_BIT_ZERO,
	input wire logic BYTE_SEL_N,
	// Acknowledge pin (open drain)
	output logic TRANSFER_ACK_N_O,
	output logic TRANSFER_ACK_N_OE,
	// Byte lane decode
	output logic LOW_LANE,
	output logic HIGH_LANE,
	output logic WORD_XFER,
	output logic DATA_OE,
	output logic [1:0] BUS_STYLE,
	// Oscillator
	input wire logic OSC_IN,
	output logic OSC_RUN,
	output logic OSC_OUT_O,
	output logic OSC_OUT_OE,
	// Channel power
	input wire logic [NUM_CHANNELS-1:0] CHANNEL_POWER_UP_WR,
	input wire logic [NUM_CHANNELS-1:0] CHANNEL_POWER_UP_VAL,
	output logic [NUM_CHANNELS-1:0] CHANNEL_POWERED,
	// Interrupt sources, masks and clears
	input wire logic [NUM_CHANNELS*CHAN_IRQ_W-1:0] CHANNEL_EVENTS,
	input wire logic [NUM_CHANNELS*CHAN_IRQ_W-1:0] CHANNEL_IRQ_MASK,
	input wire logic [NUM_CHANNELS*CHAN_IRQ_W-1:0] CHANNEL_IRQ_CLEAR,
	input wire logic [NUM_PORTS*PORT_IRQ_W-1:0] PORT_EVENTS,
	input wire logic [NUM_PORTS*PORT_IRQ_W-1:0] PORT_IRQ_MASK,
	input wire logic [NUM_PORTS*PORT_IRQ_W-1:0] PORT_IRQ_CLEAR,
	input wire logic [NUM_PORTS-1:0] PORT_IRQ_ENABLE,
	// Interrupt status
	output logic [NUM_CHANNELS*CHAN_IRQ_W-1:0] CHANNEL_IRQ_STATUS,
	output logic [NUM_PORTS*PORT_IRQ_W-1:0] PORT_IRQ_STATUS,
	output logic [GLOBAL_IRQ_W-1:0] GLOBAL_IRQ_STATUS,
	// Interrupt pin configuration and output
	input wire logic [1:0] IRQ_PIN_CONFIG,
	input wire logic CHAIN_MODE,
	input wire logic CHAIN_ENABLE_IN,
	output logic IRQ_O,
	output logic IRQ_OE
);
	logic [NUM_CHANNELS-1:0] power_reg;
	logic [NUM_CHANNELS-1:0] power_next;
	logic [NUM_CHANNELS-1:0] chan_pend;
	logic [NUM_PORTS-1:0] port_pend;
	logic [GLOBAL_IRQ_W-1:0] gis_reg;
	logic [GLOBAL_IRQ_W-1:0] gis_next;
	logic irq_req_reg;
	logic irq_req_next;
	logic lo_reg;
	logic lo_next;
	logic hi_reg;
	logic hi_next;
	logic word_reg;
	logic word_next;
	logic cycle_req;
	logic ack_act;
	logic strobe_act;
	bus_style_e style;
	irq_type_e irq_type;

	// Lane decode shared by both bus styles
	function automatic logic [2:0] lane_decode(input logic wide, input logic motor,
		input logic a0, input logic sel_act);
		logic [2:0] r;
		r = 3'b001;
		if (wide) begin
			if (motor) begin
				r = sel_act ? (a0 ? 3'b001 : 3'b111) : 3'b010; // R8
			end else begin
				r = sel_act ? (a0 ? 3'b010 : 3'b111) : 3'b001; // R7
			end
		end
		return r; // R9
	endfunction : lane_decode

	// Strobe and cycle qualification per bus style
	always_comb begin
		if (style == BUS_DEMUX_M) begin
			strobe_act = !DATA_STROBE_N;
		end else begin
			strobe_act = !READ_N || !WRITE_N;
		end
		cycle_req = !HARD_CLEAR_IN && ((!CS_N && strobe_act) || !IRQ_ACK_IN); // R13
	end

	// Acknowledge sequencing and style detection
	bus_ack_unit u_ack (
		.clk(MCLK),
		.rst_n(NRST),
		.hard_clear(HARD_CLEAR_IN),
		.cycle_req(cycle_req),
		.ale_in(ALE_IN),
		.ack_act(ack_act),
		.style(style)
	);

	// Channel status banks
	genvar c;
	generate
		for (c = 0; c < NUM_CHANNELS; c++) begin : g_chan
			irq_status_bank #(.W(CHAN_IRQ_W)) u_bank (
				.clk(MCLK),
				.rst_n(NRST),
				.hard_clear(HARD_CLEAR_IN),
				.ev_set(CHANNEL_EVENTS[c*CHAN_IRQ_W +: CHAN_IRQ_W]),
				.sw_clear(CHANNEL_IRQ_CLEAR[c*CHAN_IRQ_W +: CHAN_IRQ_W]),
				.mask(CHANNEL_IRQ_MASK[c*CHAN_IRQ_W +: CHAN_IRQ_W]), // R15
				.status(CHANNEL_IRQ_STATUS[c*CHAN_IRQ_W +: CHAN_IRQ_W]), // R16
				.pending(chan_pend[c])
			);
		end
	endgenerate

	// Port status banks; a disabled port sets no new status bits
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			irq_status_bank #(.W(PORT_IRQ_W)) u_bank (
				.clk(MCLK),
				.rst_n(NRST),
				.hard_clear(HARD_CLEAR_IN),
				.ev_set(PORT_EVENTS[p*PORT_IRQ_W +: PORT_IRQ_W]),
				.sw_clear(PORT_IRQ_CLEAR[p*PORT_IRQ_W +: PORT_IRQ_W]),
				.mask(PORT_IRQ_MASK[p*PORT_IRQ_W +: PORT_IRQ_W] |
					{PORT_IRQ_W{!PORT_IRQ_ENABLE[p]}}), // R15
				.status(PORT_IRQ_STATUS[p*PORT_IRQ_W +: PORT_IRQ_W]), // R16
				.pending(port_pend[p])
			);
		end
	endgenerate

	// Power, global status, request and lane registers' next values
	always_comb begin
		logic [2:0] lanes;
		lanes = lane_decode(BUS_WIDE, style == BUS_DEMUX_M, ADDR_BIT_ZERO, !BYTE_SEL_N); // R11
		power_next = power_reg;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (CHANNEL_POWER_UP_WR[i]) begin
				power_next[i] = CHANNEL_POWER_UP_VAL[i]; // R3
			end
		end
		gis_next = {port_pend, chan_pend}; // R16
		irq_req_next = (|chan_pend || |port_pend) && (!CHAIN_MODE || CHAIN_ENABLE_IN); // R14 R18 R19
		lo_next = lanes[0];
		hi_next = lanes[1];
		word_next = lanes[2] && BUS_WIDE; // R10
		if (HARD_CLEAR_IN) begin
			power_next = POWER_RESET; // R2
			gis_next = '0;
			irq_req_next = 1'b0; // R1
		end
	end

	// Registers
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			power_reg <= POWER_RESET;
			gis_reg <= '0;
			irq_req_reg <= 1'b0;
			lo_reg <= 1'b1;
			hi_reg <= 1'b0;
			word_reg <= 1'b0;
		end else begin
			power_reg <= power_next;
			gis_reg <= gis_next;
			irq_req_reg <= irq_req_next;
			lo_reg <= lo_next;
			hi_reg <= hi_next;
			word_reg <= word_next;
		end
	end

	assign irq_type = irq_type_e'(IRQ_PIN_CONFIG);

	// Pin drivers; interrupt and acknowledge float in hard clear, data and oscillator output only when idle
	always_comb begin
		CHANNEL_POWERED = HARD_CLEAR_IN ? {NUM_CHANNELS{1'b1}} : power_reg; // R2
		TRANSFER_ACK_N_O = 1'b0;
		TRANSFER_ACK_N_OE = ack_act && !HARD_CLEAR_IN; // R4
		OSC_RUN = !HARD_CLEAR_IN; // R6
		OSC_OUT_O = !OSC_IN;
		OSC_OUT_OE = !(HARD_CLEAR_IN && OSC_IN); // R6
		DATA_OE = !HARD_CLEAR_IN ? (!CS_N && !READ_N) || !IRQ_ACK_IN
			: !(READ_N && IRQ_ACK_IN); // R5
		unique case (irq_type)
			IRQ_PP_LOW: begin
				IRQ_O = !irq_req_reg;
				IRQ_OE = 1'b1;
			end
			IRQ_PP_HIGH: begin
				IRQ_O = irq_req_reg;
				IRQ_OE = 1'b1;
			end
			IRQ_OPEN_DRAIN, IRQ_OPEN_DRAIN2: begin
				IRQ_O = 1'b0;
				IRQ_OE = irq_req_reg; // R17
			end
		endcase
		if (HARD_CLEAR_IN) begin
			IRQ_OE = 1'b0; // R4
		end
	end

	assign LOW_LANE = lo_reg;
	assign HIGH_LANE = hi_reg;
	assign WORD_XFER = word_reg;
	assign GLOBAL_IRQ_STATUS = gis_reg;
	assign BUS_STYLE = style;

	// Chain enable low drops the request next cycle
	chain_gate_a: assert property (@(posedge MCLK) disable iff (!NRST) // R18
		(CHAIN_MODE && !CHAIN_ENABLE_IN) |=> !irq_req_reg)
		else $error("request while chain disabled");
	// No pending status means the request falls
	irq_clear_a: assert property (@(posedge MCLK) disable iff (!NRST) // R19
		(chan_pend == '0 && port_pend == '0) |=> !irq_req_reg)
		else $error("request without pending status");
	// Pending status raises the request when not gated
	irq_raise_a: assert property (@(posedge MCLK) // R14
		disable iff (!NRST || HARD_CLEAR_IN)
		(|chan_pend && !CHAIN_MODE) |=> irq_req_reg)
		else $error("pending source without request");
	// Chain enable high lets a port request through
	chain_pass_a: assert property (@(posedge MCLK) // R18
		disable iff (!NRST || HARD_CLEAR_IN)
		(|port_pend && CHAIN_MODE && CHAIN_ENABLE_IN) |=> irq_req_reg)
		else $error("request blocked with chain enabled");
	// Channels wake powered down after hard clear
	power_reset_a: assert property (@(posedge MCLK) disable iff (!NRST) // R2
		$fell(HARD_CLEAR_IN) && CHANNEL_POWER_UP_WR == '0 |-> CHANNEL_POWERED == '0)
		else $error("channel powered after hard clear");
	// Channels keep their power state without a write
	power_keep_a: assert property (@(posedge MCLK) disable iff (!NRST) // R3
		(CHANNEL_POWER_UP_WR == '0 && !HARD_CLEAR_IN) |=> $stable(power_reg))
		else $error("channel power changed by itself");
	// All channels powered while hard clear is held
	power_clear_a: assert property (@(posedge MCLK) disable iff (!NRST) // R2
		HARD_CLEAR_IN |-> &CHANNEL_POWERED)
		else $error("channel unpowered during hard clear");
	// Interrupt and acknowledge outputs float and the oscillator stops throughout hard clear
	float_reset_a: assert property (@(posedge MCLK) disable iff (!NRST) // R4
		HARD_CLEAR_IN |-> !IRQ_OE && !TRANSFER_ACK_N_OE && !OSC_RUN)
		else $error("driven output during hard clear");
	// Data lines float in hard clear with read and irq ack idle
	data_float_a: assert property (@(posedge MCLK) disable iff (!NRST) // R5
		(HARD_CLEAR_IN && READ_N && IRQ_ACK_IN) |-> !DATA_OE)
		else $error("data lines driven during hard clear");
	// Oscillator output floats in hard clear while its input is high
	osc_float_a: assert property (@(posedge MCLK) disable iff (!NRST) // R6
		(HARD_CLEAR_IN && OSC_IN) |-> !OSC_OUT_OE)
		else $error("oscillator output driven during hard clear");
	// First style: active select with odd address picks the upper lane
	upper_lane_a: assert property (@(posedge MCLK) disable iff (!NRST) // R7
		(BUS_WIDE && style != BUS_DEMUX_M && !BYTE_SEL_N && ADDR_BIT_ZERO)
		|=> HIGH_LANE && !LOW_LANE && !WORD_XFER)
		else $error("upper lane not selected");
	// Second style: active select with odd address picks the lower lane
	lower_lane_a: assert property (@(posedge MCLK) disable iff (!NRST) // R8
		(BUS_WIDE && style == BUS_DEMUX_M && !BYTE_SEL_N && ADDR_BIT_ZERO)
		|=> LOW_LANE && !HIGH_LANE && !WORD_XFER)
		else $error("lower lane not selected");
	// Sixteen-bit mode with select and even address moves a word
	word_lane_a: assert property (@(posedge MCLK) disable iff (!NRST) // R10
		(BUS_WIDE && !BYTE_SEL_N && !ADDR_BIT_ZERO) |=> WORD_XFER)
		else $error("word transfer not selected");
	// Eight-bit mode ignores byte select
	narrow_lane_a: assert property (@(posedge MCLK) disable iff (!NRST) // R9
		!BUS_WIDE |=> LOW_LANE && !HIGH_LANE && !WORD_XFER)
		else $error("byte select used in 8-bit mode");
	// Push-pull low drives the inverted request
	irq_level_a: assert property (@(posedge MCLK) // R17
		disable iff (!NRST || HARD_CLEAR_IN)
		irq_type == IRQ_PP_LOW |-> IRQ_OE && (IRQ_O == !irq_req_reg))
		else $error("wrong push-pull low level");
	// Open drain only pulls low while requesting
	irq_drain_a: assert property (@(posedge MCLK) // R17
		disable iff (!NRST || HARD_CLEAR_IN)
		(irq_type == IRQ_OPEN_DRAIN || irq_type == IRQ_OPEN_DRAIN2)
		|-> !IRQ_O && (IRQ_OE == irq_req_reg))
		else $error("wrong open-drain drive");
endmodule : host_ctl

// *** dv/host_model.sv ***
// Host processor bus master model
`timescale 1ns/1ps
module host_model (
	// Clock and acknowledge pin
	input wire logic MCLK,
	input wire logic ACK_O,
	input wire logic ACK_OE,
	// Strobes and qualifiers
	output logic CS_N,
	output logic READ_N,
	output logic WRITE_N,
	output logic DATA_STROBE_N,
	output logic IRQ_ACK_IN,
	output logic ADDR_BIT_ZERO,
	output logic BYTE_SEL_N
);
	logic ack_n;
	// Pull-up on the open-drain acknowledge wire
	assign ack_n = ACK_OE ? ACK_O : 1'b1;
	// Idle bus
	initial begin
		{CS_N, READ_N, WRITE_N, DATA_STROBE_N, IRQ_ACK_IN} = 5'h1f;
		ADDR_BIT_ZERO = 1'b0;
		BYTE_SEL_N = 1'b1;
	end
	// Kind 0 read, 1 write, 2 irq ack; m picks data strobe style; stalls extra edges
	task automatic cycle(input logic [1:0] k, input logic m, input logic a0, input logic sn,
		input int extra, output int lat, output int held);
		lat = 0;
		held = 0;
		@(negedge MCLK);
		ADDR_BIT_ZERO = a0;
		BYTE_SEL_N = sn;
		CS_N = (k == 2'd2);
		IRQ_ACK_IN = (k != 2'd2);
		READ_N = !(k == 2'd0 && !m);
		WRITE_N = !(k == 2'd1 && !m);
		DATA_STROBE_N = !(m && k != 2'd2);
		do begin
			@(posedge MCLK);
			lat++;
		end while (ack_n !== 1'b0 && lat < 16);
		if (ack_n !== 1'b0) lat = -1;
		repeat (extra) begin
			@(posedge MCLK);
			held += (ack_n === 1'b0);
		end
		@(negedge MCLK);
		{CS_N, READ_N, WRITE_N, DATA_STROBE_N, IRQ_ACK_IN} = 5'h1f;
		ADDR_BIT_ZERO = !a0;
		BYTE_SEL_N = !sn;
		@(posedge MCLK);
		@(negedge MCLK);
	endtask : cycle
endmodule : host_model

// *** dv/testbench.sv ***
// Self-checking testbench for the host port control block
`timescale 1ns/1ps
module testbench
	import hostctl_pkg::*;
;
	logic mclk = 1'b0, nrst = 1'b0, hclr = 1'b0, wide = 1'b0, ale = 1'b0, osc_in = 1'b0;
	logic [7:0] pw_wr = '0, pw_val = '0, powered;
	logic [127:0] ch_ev = '0, ch_mask = '1, ch_clr = '0, ch_st;
	logic [31:0] pt_ev = '0, pt_mask = '1, pt_clr = '0, pt_st;
	logic [3:0] pt_en = '0;
	logic [1:0] cfg = '0, style;
	logic chain = 1'b0, chain_en = 1'b0, ack_o, ack_oe, low, high, word, data_oe;
	logic osc_run, osc_o, osc_oe, irq_o, irq_oe, cs_n, rd_n, wr_n, ds_n, irq_ack_in_n, a0, sel_n;
	logic [11:0] global_irq_status;
	int mismatches = 0, checked = 0;
	// Clock
	always #2.5 mclk = ~mclk;
	host_model host (.MCLK(mclk), .ACK_O(ack_o), .ACK_OE(ack_oe), .CS_N(cs_n), .READ_N(rd_n),
		.WRITE_N(wr_n), .DATA_STROBE_N(ds_n), .IRQ_ACK_IN(irq_ack_in_n), .ADDR_BIT_ZERO(a0),
		.BYTE_SEL_N(sel_n));
	host_ctl dut (.MCLK(mclk), .NRST(nrst), .HARD_CLEAR_IN(hclr), .BUS_WIDE(wide),
		.ALE_IN(ale), .CS_N(cs_n), .READ_N(rd_n), .WRITE_N(wr_n), .DATA_STROBE_N(ds_n),
		.IRQ_ACK_IN(irq_ack_in_n), .ADDR_BIT_ZERO(a0), .BYTE_SEL_N(sel_n), .TRANSFER_ACK_N_O(ack_o),
		.TRANSFER_ACK_N_OE(ack_oe), .LOW_LANE(low), .HIGH_LANE(high), .WORD_XFER(word),
		.DATA_OE(data_oe), .BUS_STYLE(style), .OSC_IN(osc_in), .OSC_RUN(osc_run),
		.OSC_OUT_O(osc_o), .OSC_OUT_OE(osc_oe), .CHANNEL_POWER_UP_WR(pw_wr),
		.CHANNEL_POWER_UP_VAL(pw_val), .CHANNEL_POWERED(powered), .CHANNEL_EVENTS(ch_ev),
		.CHANNEL_IRQ_MASK(ch_mask), .CHANNEL_IRQ_CLEAR(ch_clr), .PORT_EVENTS(pt_ev),
		.PORT_IRQ_MASK(pt_mask), .PORT_IRQ_CLEAR(pt_clr), .PORT_IRQ_ENABLE(pt_en),
		.CHANNEL_IRQ_STATUS(ch_st), .PORT_IRQ_STATUS(pt_st), .GLOBAL_IRQ_STATUS(global_irq_status),
		.IRQ_PIN_CONFIG(cfg), .CHAIN_MODE(chain), .CHAIN_ENABLE_IN(chain_en),
		.IRQ_O(irq_o), .IRQ_OE(irq_oe));
	// Value comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Latency comparison against a window of edges
	task automatic chk_lat(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("[FAIL] %0t latency %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_lat
	// Interrupt pin level and enable for the current pin type
	task automatic irq_chk(input logic act);
		chk({irq_oe, irq_o}, {(cfg < 2'd2) | act, (cfg == 2'd1) ? act : (cfg == 2'd0) & !act});
	endtask : irq_chk
	// One bus cycle; lanes {low, high, word} sampled while the cycle is held
	task automatic bus(input logic [1:0] k, input logic av, input logic sn, input logic [2:0] exp,
		input logic [2:0] m);
		int lat, held;
		logic [2:0] got;
		fork
			host.cycle(k, ale, av, sn, 2, lat, held);
			begin
				repeat (3) @(negedge mclk);
				got = {low, high, word};
			end
		join
		chk_lat(lat, ACK_DELAY_CYC + 1, ACK_DELAY_CYC + 3);
		chk(held, 2);
		chk(ack_oe, 1'b0);
		chk(got & m, exp);
	endtask : bus
	// Event or clear pulse on a channel or port bit
	task automatic pulse(input logic p, input int i, input logic clr);
		if (p && clr) pt_clr[i] = 1'b1;
		else if (p) pt_ev[i] = 1'b1;
		else if (clr) ch_clr[i] = 1'b1;
		else ch_ev[i] = 1'b1;
		@(negedge mclk);
		{ch_ev, ch_clr} = '0;
		{pt_ev, pt_clr} = '0;
		repeat (2) @(negedge mclk);
	endtask : pulse
	// Verdict
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// Watchdog
	initial begin
		#20000;
		mismatches++;
		end_sim();
	end
	// Test sequence
	initial begin
		int lat, held;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		hclr = 1'b1;
		osc_in = 1'b1;
		repeat (2) @(negedge mclk);
		chk({irq_oe, ack_oe, data_oe, osc_oe, osc_run}, 5'h00);
		chk(powered, 8'hff);
		host.cycle(2'd0, 1'b0, 1'b0, 1'b1, 0, lat, held);
		chk(lat, 32'hffffffff);
		osc_in = 1'b0;
		@(negedge mclk);
		chk({osc_oe, osc_o}, 2'b11);
		hclr = 1'b0;
		repeat (4) @(negedge mclk);
		chk({powered, osc_run}, {POWER_RESET, 1'b1});
		pw_wr = 8'h08;
		pw_val = 8'h08;
		@(negedge mclk);
		pw_wr = 8'h00;
		repeat (2) @(negedge mclk);
		chk(powered, 8'h08);
		// Lane decode in both sixteen-bit styles, then eight-bit
		wide = 1'b1;
		for (int s = 0; s < 2; s++) begin
			ale = s[0];
			repeat (6) @(negedge mclk);
			chk(style, s[1:0]);
			bus(2'd0, 1'b0, 1'b0, 3'b001, 3'b001);
			bus(2'd1, 1'b1, 1'b0, s ? 3'b100 : 3'b010, 3'b111);
			bus(2'd0, 1'b1, 1'b1, s ? 3'b010 : 3'b100, 3'b111);
		end
		ale = 1'b0;
		wide = 1'b0;
		repeat (6) @(negedge mclk);
		bus(2'd1, 1'b0, 1'b0, 3'b100, 3'b111);
		bus(2'd2, 1'b1, 1'b1, 3'b100, 3'b111);
		for (int t = 0; t < 8; t++) begin
			ale = !ale;
			@(negedge mclk);
		end
		chk(style, BUS_MUX_I);
		// Masked event, then every pin type with set and clear
		pulse(1'b0, 37, 1'b0);
		chk({ch_st[37], irq_oe & !irq_o}, 2'b00);
		ch_mask[32] = 1'b0;
		ch_ev[32] = 1'b1;
		pulse(1'b0, 32, 1'b1);
		chk(ch_st[32], 1'b1);
		pulse(1'b0, 32, 1'b1);
		chk({ch_st[32], global_irq_status}, 13'h0000);
		ch_mask[37] = 1'b0;
		for (int c = 0; c < 4; c++) begin
			cfg = c[1:0];
			@(negedge mclk);
			pulse(1'b0, 37, 1'b0);
			chk({ch_st[37], global_irq_status}, {1'b1, 12'h004});
			irq_chk(1'b1);
			pulse(1'b0, 37, 1'b1);
			irq_chk(1'b0);
		end
		// Port sources, enable gate and chain gating
		pt_mask[19] = 1'b0;
		pulse(1'b1, 19, 1'b0);
		irq_chk(1'b0);
		pt_mask[11] = 1'b0;
		pt_en[1] = 1'b1;
		pulse(1'b1, 11, 1'b0);
		chk({pt_st[11], global_irq_status}, {1'b1, 12'h200});
		irq_chk(1'b1);
		chain = 1'b1;
		repeat (2) @(negedge mclk);
		irq_chk(1'b0);
		chain_en = 1'b1;
		repeat (2) @(negedge mclk);
		irq_chk(1'b1);
		pulse(1'b1, 11, 1'b1);
		irq_chk(1'b0);
		end_sim();
	end
endmodule : testbench
